// ### rtl/mfrc_pkg.sv
// Package for the modem frequency and symbol rate configuration bank
package mfrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register access port
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] CARRIER_WORD_MIDDLE_OFS         = 6'h0E;
    localparam logic [ADDR_W-1:0] CARRIER_WORD_LOW_OFS            = 6'h0F;
    localparam logic [ADDR_W-1:0] BANDWIDTH_RATE_EXPONENT_CFG_OFS = 6'h10;
    localparam logic [ADDR_W-1:0] SYMBOL_RATE_MANTISSA_CFG_OFS    = 6'h11;
    localparam logic [ADDR_W-1:0] MODULATION_FILTER_CFG_OFS       = 6'h12;

    // Reset values
    localparam logic [7:0] CARRIER_WORD_MIDDLE_RST  = 8'hC4;
    localparam logic [7:0] CARRIER_WORD_LOW_RST     = 8'hEC;
    localparam logic [1:0] BANDWIDTH_EXPONENT_RST   = 2'h2;
    localparam logic [1:0] BANDWIDTH_MANTISSA_RST   = 2'h0;
    localparam logic [3:0] SYMBOL_RATE_EXPONENT_RST = 4'hC;
    localparam logic [7:0] SYMBOL_RATE_MANTISSA_RST = 8'h22;
    localparam logic       DC_BLOCK_BYPASS_RST      = 1'b0;
    localparam logic [2:0] MODULATION_SELECT_RST    = 3'h0;
    localparam logic [7:0] UNMAPPED_READ_VAL        = 8'h00;

    // Field positions
    localparam int BW_EXP_MSB  = 7;
    localparam int BW_EXP_LSB  = 6;
    localparam int BW_MANT_MSB = 5;
    localparam int BW_MANT_LSB = 4;
    localparam int SR_EXP_MSB  = 3;
    localparam int SR_EXP_LSB  = 0;
    localparam int DC_BYP_BIT  = 7;
    localparam int MOD_MSB     = 6;
    localparam int MOD_LSB     = 4;
    localparam int MOD_CFG_LOW_MSB = 3;

    // Modulation codes
    localparam logic [2:0] MOD_CODE_FSK2 = 3'h0;
    localparam logic [2:0] MOD_CODE_GFSK = 3'h1;
    localparam logic [2:0] MOD_CODE_ASK  = 3'h3;
    localparam logic [2:0] MOD_CODE_MSK  = 3'h7;

    // Rate limits and crystal for the limit flags; the hidden one also forms the significand output
    localparam longint XTAL_HZ            = 26000000;
    localparam longint DC_BYPASS_MAX_BAUD = 250000;
    localparam longint MSK_MIN_BAUD       = 26000;
    localparam int     RATE_FRAC_BITS     = 28;
    localparam logic [8:0] HIDDEN_ONE     = 9'h100;

    typedef enum logic [2:0] {
        MFRC_MOD_FSK2,
        MFRC_MOD_GFSK,
        MFRC_MOD_ASK_OOK,
        MFRC_MOD_MSK,
        MFRC_MOD_NONE
    } mfrc_mod_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mfrc_req_t;

    typedef struct packed {
        logic [23:0] carrier_word;
        logic [1:0]  bandwidth_exponent;
        logic [1:0]  bandwidth_mantissa;
        logic [3:0]  symbol_rate_exponent;
        logic [7:0]  symbol_rate_mantissa;
        logic [8:0]  symbol_rate_significand;
        logic        dc_block_enable;
        mfrc_mod_t   modulation;
    } mfrc_cfg_t;

endpackage

// ### rtl/mfrc_regs.sv
// Modem frequency, bandwidth, symbol rate and modulation register bank
// Notes on behaviour
// - Middle carrier byte, read/write, resets to C4.
// - Low carrier byte, read/write, resets to EC.
// - Three bytes form a 24-bit base frequency word; top two bits read zero.
// - Bandwidth exponent bits 7:6 reset 2, mantissa bits 5:4 reset 0.
// - Symbol rate exponent in bits 3:0 of the same register, reset 12.
// - Symbol rate mantissa in its own register, reset 22.
// - Rate significand is mantissa with hidden ninth bit one; only the limit flags scale it by exponent.
// - Bit 7 clear enables the DC blocking filter; bypass only up to 250 kBaud.
// - Modulation field bits 6:4: 000 2-FSK, 001 GFSK, 010 unassigned.
// - 011 ASK/OOK, 111 MSK, 100-110 unassigned; MSK only above 26 kBaud.
module mfrc_regs
    import mfrc_pkg::*;
(
    input  wire logic                clk_i,            // 25 MHz clock
    input  wire logic                rst_i,            // Synchronous reset, high
    input  wire logic                ce_i,             // Clock enable, freezes all state
    input  wire mfrc_pkg::mfrc_req_t req_i,            // Register access request
    input  wire logic [5:0]          carrier_high_i,   // Carrier word bits 21:16
    output logic [7:0]               rdata_o,          // Read data, registered
    output logic                     rvalid_o,         // Read data valid pulse
    output mfrc_pkg::mfrc_cfg_t      cfg_o,            // Decoded configuration
    output logic                     mod_unassigned_o, // Modulation code has no format
    output logic                     dc_bypass_fast_o, // Bypass set above rate limit
    output logic                     msk_slow_o        // MSK set at or below rate limit
);
    import mfrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Significand with the hidden ninth bit
    function automatic logic [8:0] rate_sig(input logic [7:0] mant);
        rate_sig = HIDDEN_ONE | {1'b0, mant};
    endfunction

    // True when the symbol rate is above the given baud figure
    function automatic logic rate_above(input logic [7:0] mant, input logic [3:0] expo,
                                        input longint baud);
        longint lhs;
        longint rhs;
        lhs = longint'(rate_sig(mant)) * (longint'(1) << expo) * XTAL_HZ;
        rhs = baud << RATE_FRAC_BITS;
        rate_above = lhs > rhs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] carrier_word_middle_r, carrier_word_middle_nxt;
    logic [7:0] carrier_word_low_r, carrier_word_low_nxt;
    logic [1:0] bandwidth_exponent_r, bandwidth_exponent_nxt;
    logic [1:0] bandwidth_mantissa_r, bandwidth_mantissa_nxt;
    logic [3:0] symbol_rate_exponent_r, symbol_rate_exponent_nxt;
    logic [7:0] symbol_rate_mantissa_r, symbol_rate_mantissa_nxt;
    logic       dc_block_bypass_r, dc_block_bypass_nxt;
    logic [2:0] modulation_select_r, modulation_select_nxt;
    logic [3:0] mod_cfg_low_r, mod_cfg_low_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;
    logic [7:0] read_mux;

    // Write decode and next values
    always_comb begin
        carrier_word_middle_nxt  = carrier_word_middle_r;
        carrier_word_low_nxt     = carrier_word_low_r;
        bandwidth_exponent_nxt   = bandwidth_exponent_r;
        bandwidth_mantissa_nxt   = bandwidth_mantissa_r;
        symbol_rate_exponent_nxt = symbol_rate_exponent_r;
        symbol_rate_mantissa_nxt = symbol_rate_mantissa_r;
        dc_block_bypass_nxt      = dc_block_bypass_r;
        modulation_select_nxt    = modulation_select_r;
        mod_cfg_low_nxt          = mod_cfg_low_r;
        if (req_i.wr) begin
            case (req_i.addr)
                CARRIER_WORD_MIDDLE_OFS: begin
                    carrier_word_middle_nxt = req_i.wdata;
                end
                CARRIER_WORD_LOW_OFS: begin
                    carrier_word_low_nxt = req_i.wdata;
                end
                BANDWIDTH_RATE_EXPONENT_CFG_OFS: begin
                    bandwidth_exponent_nxt   = req_i.wdata[BW_EXP_MSB:BW_EXP_LSB];
                    bandwidth_mantissa_nxt   = req_i.wdata[BW_MANT_MSB:BW_MANT_LSB];
                    symbol_rate_exponent_nxt = req_i.wdata[SR_EXP_MSB:SR_EXP_LSB];
                end
                SYMBOL_RATE_MANTISSA_CFG_OFS: begin
                    symbol_rate_mantissa_nxt = req_i.wdata;
                end
                MODULATION_FILTER_CFG_OFS: begin
                    dc_block_bypass_nxt   = req_i.wdata[DC_BYP_BIT];
                    modulation_select_nxt = req_i.wdata[MOD_MSB:MOD_LSB];
                    mod_cfg_low_nxt       = req_i.wdata[MOD_CFG_LOW_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux of the stored fields
    always_comb begin
        case (req_i.addr)
            CARRIER_WORD_MIDDLE_OFS:         read_mux = carrier_word_middle_r;
            CARRIER_WORD_LOW_OFS:            read_mux = carrier_word_low_r;
            BANDWIDTH_RATE_EXPONENT_CFG_OFS: read_mux = {bandwidth_exponent_r, bandwidth_mantissa_r,
                                                         symbol_rate_exponent_r};
            SYMBOL_RATE_MANTISSA_CFG_OFS:    read_mux = symbol_rate_mantissa_r;
            MODULATION_FILTER_CFG_OFS:       read_mux = {dc_block_bypass_r, modulation_select_r,
                                                         mod_cfg_low_r};
            default:                         read_mux = UNMAPPED_READ_VAL;
        endcase
        rdata_nxt  = req_i.rd ? read_mux : rdata_r;
        rvalid_nxt = req_i.rd;
    end

    // State registers with reset values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carrier_word_middle_r  <= CARRIER_WORD_MIDDLE_RST;
            carrier_word_low_r     <= CARRIER_WORD_LOW_RST;
            bandwidth_exponent_r   <= BANDWIDTH_EXPONENT_RST;
            bandwidth_mantissa_r   <= BANDWIDTH_MANTISSA_RST;
            symbol_rate_exponent_r <= SYMBOL_RATE_EXPONENT_RST;
            symbol_rate_mantissa_r <= SYMBOL_RATE_MANTISSA_RST;
            dc_block_bypass_r      <= DC_BLOCK_BYPASS_RST;
            modulation_select_r    <= MODULATION_SELECT_RST;
            mod_cfg_low_r          <= '0;
            rdata_r                <= '0;
            rvalid_r               <= 1'b0;
        end else if (ce_i) begin
            carrier_word_middle_r  <= carrier_word_middle_nxt;
            carrier_word_low_r     <= carrier_word_low_nxt;
            bandwidth_exponent_r   <= bandwidth_exponent_nxt;
            bandwidth_mantissa_r   <= bandwidth_mantissa_nxt;
            symbol_rate_exponent_r <= symbol_rate_exponent_nxt;
            symbol_rate_mantissa_r <= symbol_rate_mantissa_nxt;
            dc_block_bypass_r      <= dc_block_bypass_nxt;
            modulation_select_r    <= modulation_select_nxt;
            mod_cfg_low_r          <= mod_cfg_low_nxt;
            rdata_r                <= rdata_nxt;
            rvalid_r               <= rvalid_nxt;
        end
    end

    assign rdata_o  = rdata_r;
    assign rvalid_o = rvalid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs
    mfrc_mod_t mod_dec;

    // Modulation format decode
    always_comb begin
        case (modulation_select_r)
            MOD_CODE_FSK2: mod_dec = MFRC_MOD_FSK2;
            MOD_CODE_GFSK: mod_dec = MFRC_MOD_GFSK;
            MOD_CODE_ASK:  mod_dec = MFRC_MOD_ASK_OOK;
            MOD_CODE_MSK:  mod_dec = MFRC_MOD_MSK;
            default:       mod_dec = MFRC_MOD_NONE;
        endcase
    end

    // Frequency word, rate significand and filter control
    always_comb begin
        cfg_o.carrier_word            = {2'b00, carrier_high_i, carrier_word_middle_r,
                                         carrier_word_low_r};
        cfg_o.bandwidth_exponent      = bandwidth_exponent_r;
        cfg_o.bandwidth_mantissa      = bandwidth_mantissa_r;
        cfg_o.symbol_rate_exponent    = symbol_rate_exponent_r;
        cfg_o.symbol_rate_mantissa    = symbol_rate_mantissa_r;
        cfg_o.symbol_rate_significand = rate_sig(symbol_rate_mantissa_r);
        cfg_o.dc_block_enable         = !dc_block_bypass_r;
        cfg_o.modulation              = mod_dec;
    end

    // Unassigned modulation flag and limit flags for settings outside the supported rate range
    assign mod_unassigned_o = (mod_dec == MFRC_MOD_NONE);
    assign dc_bypass_fast_o = dc_block_bypass_r &&
                              rate_above(symbol_rate_mantissa_r, symbol_rate_exponent_r,
                                         DC_BYPASS_MAX_BAUD);
    assign msk_slow_o       = (mod_dec == MFRC_MOD_MSK) &&
                              !rate_above(symbol_rate_mantissa_r, symbol_rate_exponent_r,
                                          MSK_MIN_BAUD);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    middle_reset_val_a: assert property ($past(rst_i) |-> carrier_word_middle_r == CARRIER_WORD_MIDDLE_RST)
        else $error("middle byte reset value wrong");
    low_reset_val_a: assert property ($past(rst_i) |-> carrier_word_low_r == CARRIER_WORD_LOW_RST)
        else $error("low byte reset value wrong");
    carrier_word_top_zero_a: assert property (cfg_o.carrier_word[23:22] == 2'b00 &&
                                      cfg_o.carrier_word[15:0] == {carrier_word_middle_r,
                                                                   carrier_word_low_r})
        else $error("carrier word assembly wrong");
    bw_write_a: assert property (ce_i && req_i.wr && req_i.addr == BANDWIDTH_RATE_EXPONENT_CFG_OFS
                                 |=> {bandwidth_exponent_r, bandwidth_mantissa_r, symbol_rate_exponent_r}
                                     == $past(req_i.wdata))
        else $error("bandwidth register not updated");
    exp_reset_val_a: assert property ($past(rst_i) |-> symbol_rate_exponent_r == SYMBOL_RATE_EXPONENT_RST &&
                                      bandwidth_exponent_r == BANDWIDTH_EXPONENT_RST)
        else $error("exponent reset value wrong");
    mant_write_a: assert property (ce_i && req_i.wr && req_i.addr == SYMBOL_RATE_MANTISSA_CFG_OFS
                                   |=> symbol_rate_mantissa_r == $past(req_i.wdata))
        else $error("mantissa not updated");
    hidden_one_a: assert property (cfg_o.symbol_rate_significand[8] &&
                                   cfg_o.symbol_rate_significand[7:0] == symbol_rate_mantissa_r)
        else $error("significand hidden bit wrong");
    dc_filter_a: assert property (ce_i && req_i.wr && req_i.addr == MODULATION_FILTER_CFG_OFS
                                  |=> cfg_o.dc_block_enable == !$past(req_i.wdata[DC_BYP_BIT]))
        else $error("dc filter enable wrong");
    mod_decode_a: assert property (((modulation_select_r == MOD_CODE_GFSK) == (cfg_o.modulation == MFRC_MOD_GFSK))
                                   && (modulation_select_r != 3'h2 || mod_unassigned_o))
        else $error("modulation decode wrong");
    msk_decode_a: assert property ((modulation_select_r == MOD_CODE_MSK) == (cfg_o.modulation == MFRC_MOD_MSK)
                                   && (modulation_select_r == MOD_CODE_ASK) ==
                                      (cfg_o.modulation == MFRC_MOD_ASK_OOK))
        else $error("msk or ask decode wrong");
    read_back_a: assert property (ce_i && req_i.wr && req_i.addr == CARRIER_WORD_LOW_OFS
                                  ##1 ce_i && req_i.rd && !req_i.wr && req_i.addr == CARRIER_WORD_LOW_OFS
                                  |=> rvalid_o && rdata_o == $past(req_i.wdata, 2))
        else $error("read back mismatch");
    ce_freeze_a: assert property (!ce_i |=> $stable(carrier_word_middle_r) && $stable(carrier_word_low_r)
                                  && $stable(rdata_o)
                                  && $stable(rvalid_o))
        else $error("state moved with clock enable low");

endmodule

// ### tb/mfrc_host_model.sv
// Host side model driving the register port of the configuration bank
module mfrc_host_model
    import mfrc_pkg::*;
(
    input  wire logic           clk_i,    // Bank clock
    input  wire logic [7:0]     rdata_i,  // Read data from the bank
    input  wire logic           rvalid_i, // Read data valid pulse
    output mfrc_pkg::mfrc_req_t req_o     // Register access request
);
    timeunit 1ns;
    timeprecision 1ns;

    logic if_recalc_r; // Filter bypass written, IF setting is stale

    // Idle request at time zero
    initial begin
        req_o = '0;
        if_recalc_r = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One write, held until the edge that takes it
    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        req_o.wr <= 1'b1;
        req_o.addr <= addr;
        req_o.wdata <= data;
        @(posedge clk_i);
        req_o.wr <= 1'b0;
        if (addr == 6'h12 && data[7]) begin
            if_recalc_r = 1'b1;
        end
    endtask

    // Write, then a read of the same place in the very next cycle
    task automatic wr_rd_b2b(input logic [5:0] addr, input logic [7:0] data, output logic [7:0] rdat,
                             output logic ok);
        @(posedge clk_i);
        req_o.wr <= 1'b1;
        req_o.addr <= addr;
        req_o.wdata <= data;
        @(posedge clk_i);
        req_o.wr <= 1'b0;
        req_o.rd <= 1'b1;
        @(posedge clk_i);
        req_o.rd <= 1'b0;
        #1;
        ok = rvalid_i;
        rdat = rdata_i;
    endtask

    // One read; answer sampled after the taking edge settles
    task automatic rd(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk_i);
        req_o.rd <= 1'b1;
        req_o.addr <= addr;
        @(posedge clk_i);
        req_o.rd <= 1'b0;
        #1;
        ok = rvalid_i;
        data = rdata_i;
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the modem configuration register bank
module tb
    import mfrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_i;
    logic       rst_i;
    logic       ce_i;
    logic [5:0] carrier_high_i;
    mfrc_req_t  req;
    logic [7:0] rdata;
    logic       rvalid;
    mfrc_cfg_t  cfg;
    logic       mod_un;
    logic       byp_fast;
    logic       msk_slow;
    logic [7:0] shadow [5];
    logic [7:0] got;
    logic       ok;
    int         fail_count;
    int         tests_run;
    int         cycles;
    int         seed;
    logic [15:0] corner [6] = '{16'h0FFF, 16'h0000, 16'h0D3B, 16'h0D3C, 16'h0A06, 16'h0A07};

    mfrc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req), .carrier_high_i(carrier_high_i),
        .rdata_o(rdata), .rvalid_o(rvalid), .cfg_o(cfg), .mod_unassigned_o(mod_un),
        .dc_bypass_fast_o(byp_fast), .msk_slow_o(msk_slow));
    mfrc_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expected values
    function automatic logic [31:0] rd_exp(input logic [5:0] a);
        if (a >= 6'h0E && a <= 6'h12) return {24'h0, shadow[a - 6'h0E]};
        return 32'h0;
    endfunction

    // True when the programmed symbol rate exceeds lim baud
    function automatic logic above(input longint lim);
        longint sig;
        sig = longint'(256 + shadow[3]) << shadow[2][3:0];
        return sig * XTAL_HZ > (lim << 28);
    endfunction

    function automatic mfrc_mod_t mod_exp(input logic [2:0] c);
        case (c)
            3'h0: return MFRC_MOD_FSK2;
            3'h1: return MFRC_MOD_GFSK;
            3'h3: return MFRC_MOD_ASK_OOK;
            3'h7: return MFRC_MOD_MSK;
            default: return MFRC_MOD_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Checking tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, g, e);
        end
    endtask

    task automatic chk_cfg();
        chk(cfg.carrier_word, {2'b00, carrier_high_i, shadow[0], shadow[1]}, "carrier");
        chk(cfg.bandwidth_exponent, shadow[2][7:6], "bw exp");
        chk(cfg.bandwidth_mantissa, shadow[2][5:4], "bw mant");
        chk(cfg.symbol_rate_exponent, shadow[2][3:0], "rate exp");
        chk(cfg.symbol_rate_mantissa, shadow[3], "rate mant");
        chk(cfg.symbol_rate_significand, {1'b1, shadow[3]}, "significand");
        chk(cfg.dc_block_enable, !shadow[4][7], "dc enable");
        chk(cfg.modulation, mod_exp(shadow[4][6:4]), "modulation");
        chk(mod_un, mod_exp(shadow[4][6:4]) == MFRC_MOD_NONE, "unassigned");
        chk(byp_fast, shadow[4][7] && above(DC_BYPASS_MAX_BAUD), "bypass fast");
        chk(msk_slow, shadow[4][6:4] == 3'h7 && !above(MSK_MIN_BAUD), "msk slow");
    endtask

    task automatic rd_chk(input logic [5:0] a);
        host.rd(a, got, ok);
        chk(ok, 1, "rvalid");
        chk(got, rd_exp(a), "rdata");
        chk_cfg();
    endtask

    task automatic wr_rd(input logic [5:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a >= 6'h0E && a <= 6'h12) shadow[a - 6'h0E] = d;
        rd_chk(a);
    endtask

    // Reset for 16 cycles, then read every place back
    task automatic reset_chk();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        shadow = '{8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h00};
        for (int a = 13; a <= 19; a++) rd_chk(6'(a));
        $display("test reset values done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 50;
        rst_i = 1'b1;
        ce_i = 1'b1;
        carrier_high_i = 6'h1E;
        reset_chk();
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_i);
            carrier_high_i <= 6'($random(seed));
            wr_rd(6'h0C + 6'($random(seed) & 7), 8'($random(seed)));
        end
        $display("test random access done");
        for (int c = 0; c < 8; c++) wr_rd(6'h12, {1'b0, 3'(c), 4'h5});
        $display("test modulation codes done");
        // Back-to-back write and read of the low carrier byte
        for (int i = 0; i < 4; i++) begin
            shadow[1] = 8'($random(seed));
            host.wr_rd_b2b(6'h0F, shadow[1], got, ok);
            chk(ok, 1, "b2b rvalid");
            chk(got, shadow[1], "b2b rdata");
            chk_cfg();
        end
        $display("test back to back done");
        foreach (corner[k]) begin
            wr_rd(6'h10, corner[k][15:8]);
            wr_rd(6'h11, corner[k][7:0]);
            wr_rd(6'h12, 8'h80);
            wr_rd(6'h12, 8'h70);
        end
        $display("test rate limits done");
        @(posedge clk_i);
        ce_i <= 1'b0;
        host.wr(6'h0F, ~shadow[1]);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd_chk(6'h0F);
        $display("test clock enable done");
        reset_chk();
        wrap_up();
    end
endmodule
